// File: rtl/boot_read_handler.sv
// Notes on behaviour
// - Read reply: 81h, length N+1, 15h, data, sum, 03h
// - At most 1024 bytes per reply; then wait for host
// - Wait for command start byte, drop others
// - Missing terminator gives packet error
// - Bad check byte gives checksum error
// - Wrong length bytes give packet error
// - Any error: abandon, back to command wait
// - Lifecycle refusing read gives acceptance error
// - Encrypted write without reset: acceptance error
// - Start above end gives parameter error
// - Location outside area gives parameter error
// - Different area kinds give parameter error
// - Zero or misaligned read unit: parameter error
// - Inaccessible location gives invalid address error
// - Level one with secure region: secure error
// - Level zero refuses every read: secure error
// - Report highest error only; detail fields FFFFFFFFh
// - Host acknowledges each packet but the last; seek data start byte
// - Host packet faults give packet/checksum error
// - External flash read directly, host configures it
// - CRC-32, init FFFFFFFFh, left shift, 04C11DB7h
// - CRC steps location by location, start to end
// - Error reply: length 0Ah, 95h, status, fields
`timescale 1ns/1ps

module boot_read_handler
   import boot_read_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Received bytes from the serial link logic
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   // Bytes to the serial link logic
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   input  wire logic        tx_ready,
   // Memory read port, memory-mapped for every area
   output logic             mem_req,
   output logic      [31:0] mem_addr,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  mem_rdata,
   // Area information queries and answers
   output logic      [31:0] start_location,
   output logic      [31:0] end_location,
   input  wire area_info_t  start_info,
   input  wire area_info_t  end_info,
   input  wire logic        range_accessible,
   input  wire logic        range_secure,
   // Lifecycle and authentication state
   input  wire logic        lifecycle_allows_read,
   input  wire logic        encrypted_write_pending,
   input  wire logic        auth_level_zero,
   input  wire logic        auth_level_one,
   // Running CRC of the bytes read
   output logic      [31:0] read_crc
);

   // ----------------------------------------------------------------
   // State and helpers
   // ----------------------------------------------------------------
   ctl_t        st_ff;
   ctl_t        nxt_st;
   logic [31:0] crc_step;
   logic [31:0] remain;
   logic [9:0]  chunk_last;
   logic [15:0] len_now;
   logic [31:0] unit_mask;
   logic [7:0]  head_byte;
   logic [3:0]  head_last;
   logic        start_err;
   logic        start_data;
   logic [7:0]  err_code;

   // CRC over each byte fetched from memory
   crc32_byte #(
      .POLY    (CRC_POLY)
   ) u_crc (
      .crc_in  (st_ff.crc),
      .data_in (mem_rdata),
      .crc_out (crc_step)
   );

   // Size of the next reply, capped at 1024 payload bytes
   always_comb begin
      remain     = st_ff.endl - st_ff.cur;
      chunk_last = (remain >= MAX_CHUNK_LAST) ? MAX_CHUNK_LAST[9:0] : remain[9:0];
      len_now    = {st_ff.len[15:8], rx_data};
      unit_mask  = start_info.read_unit_size - 32'h0000_0001;
      head_last  = st_ff.is_err ? ERR_HEAD_LAST : DATA_HEAD_LAST;
   end

   // Header bytes of both reply kinds
   always_comb begin
      case (st_ff.idx)
         4'h0:    head_byte = DATA_START;
         4'h1:    head_byte = st_ff.is_err ? 8'h00 : {5'h00, st_ff.plen[10:8]};
         4'h2:    head_byte = st_ff.is_err ? ERR_LEN : st_ff.plen[7:0];
         4'h3:    head_byte = st_ff.is_err ? ERR_CODE : READ_CODE;
         4'h4:    head_byte = st_ff.sts;
         default: head_byte = UNUSED_BYTE;
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st     = st_ff;
      start_err  = 1'b0;
      start_data = 1'b0;
      err_code   = STS_PACKET;
      case (st_ff.state)
         // Hunt for the command start byte
         ST_WAIT_CMD: begin
            if (rx_valid && rx_data == CMD_START) begin
               nxt_st.state    = ST_LNH;
               nxt_st.ack_mode = 1'b0;
               nxt_st.sum      = 8'h00;
               nxt_st.cnt      = 16'h0000;
            end
         end
         // Hunt for the host data packet start byte
         ST_WAIT_ACK: begin
            if (rx_valid && rx_data == DATA_START) begin
               nxt_st.state    = ST_LNH;
               nxt_st.ack_mode = 1'b1;
               nxt_st.sum      = 8'h00;
               nxt_st.cnt      = 16'h0000;
            end
         end
         ST_LNH: begin
            if (rx_valid) begin
               nxt_st.len[15:8] = rx_data;
               nxt_st.sum       = st_ff.sum + rx_data;
               nxt_st.state     = ST_LNL;
            end
         end
         ST_LNL: begin
            if (rx_valid) begin
               nxt_st.len[7:0] = rx_data;
               nxt_st.sum      = st_ff.sum + rx_data;
               nxt_st.state    = (len_now == 16'h0000) ? ST_SUM : ST_BODY;
            end
         end
         // Body bytes: the length field decides how many
         ST_BODY: begin
            if (rx_valid) begin
               if (st_ff.cnt == 16'h0000) begin
                  nxt_st.first_byte = rx_data;
               end else begin
                  nxt_st.body = {st_ff.body[55:0], rx_data};
               end
               nxt_st.sum = st_ff.sum + rx_data;
               nxt_st.cnt = st_ff.cnt + 16'h0001;
               if (st_ff.cnt + 16'h0001 == st_ff.len) begin
                  nxt_st.state = ST_SUM;
               end
            end
         end
         ST_SUM: begin
            if (rx_valid) begin
               nxt_st.sum   = st_ff.sum + rx_data;
               nxt_st.state = ST_ETX;
            end
         end
         // Framing checks, highest priority first
         ST_ETX: begin
            if (rx_valid) begin
               if (rx_data != TERMINATOR) begin
                  start_err = 1'b1;
                  err_code  = STS_PACKET;
               end else if (st_ff.sum != 8'h00) begin
                  start_err = 1'b1;
                  err_code  = STS_CHECKSUM;
               end else if (st_ff.len == 16'h0000 || st_ff.len > MAX_LEN) begin
                  start_err = 1'b1;
                  err_code  = STS_PACKET;
               end else if (st_ff.ack_mode) begin
                  if (st_ff.first_byte != READ_CODE || st_ff.len != ACK_LEN) begin
                     start_err = 1'b1;
                     err_code  = STS_PACKET;
                  end else begin
                     start_data = 1'b1;
                  end
               end else if (st_ff.len != CMD_LEN || st_ff.first_byte != READ_CODE) begin
                  start_err = 1'b1;
                  err_code  = STS_PACKET;
               end else begin
                  nxt_st.cur   = st_ff.body[63:32];
                  nxt_st.endl  = st_ff.body[31:0];
                  nxt_st.state = ST_CHECK;
               end
            end
         end
         // Acceptance, parameter, address and secure checks in order
         ST_CHECK: begin
            start_err = 1'b1;
            if (!lifecycle_allows_read) begin
               err_code = STS_ACCEPT;
            end else if (encrypted_write_pending) begin
               err_code = STS_ACCEPT;
            end else if (st_ff.cur > st_ff.endl) begin
               err_code = STS_PARAM;
            end else if (!start_info.in_range || !end_info.in_range) begin
               err_code = STS_PARAM;
            end else if (start_info.area_kind != end_info.area_kind) begin
               err_code = STS_PARAM;
            end else if (start_info.read_unit_size == 32'h0000_0000) begin
               err_code = STS_PARAM;
            end else if ((st_ff.cur & unit_mask) != 32'h0000_0000 ||
                         (st_ff.endl & unit_mask) != unit_mask) begin
               err_code = STS_PARAM;
            end else if (!range_accessible) begin
               err_code = STS_ADDRESS;
            end else if (auth_level_one && range_secure) begin
               err_code = STS_SECURE;
            end else if (auth_level_zero) begin
               err_code = STS_SECURE;
            end else begin
               start_err   = 1'b0;
               start_data  = 1'b1;
               nxt_st.crc  = CRC_INIT;
               nxt_st.done = 1'b0;
            end
         end
         // Header bytes of either reply
         ST_HEAD: begin
            if (!st_ff.tx_valid) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data  = head_byte;
            end else if (tx_ready) begin
               nxt_st.tx_valid = 1'b0;
               nxt_st.idx      = st_ff.idx + 4'h1;
               if (st_ff.idx != 4'h0) begin
                  nxt_st.sum = st_ff.sum + st_ff.tx_data;
               end
               if (st_ff.idx == head_last) begin
                  nxt_st.state = st_ff.is_err ? ST_TSUM : ST_FETCH;
               end
            end
         end
         // Direct memory-mapped read of one byte
         ST_FETCH: begin
            nxt_st.mem_req = !mem_ack;
            if (mem_ack) begin
               nxt_st.tx_data  = mem_rdata;
               nxt_st.tx_valid = 1'b1;
               nxt_st.crc      = crc_step;
               nxt_st.done     = (st_ff.cur == st_ff.endl);
               nxt_st.cur      = st_ff.cur + 32'h0000_0001;
               nxt_st.state    = ST_DATA;
            end
         end
         ST_DATA: begin
            if (tx_ready) begin
               nxt_st.tx_valid = 1'b0;
               nxt_st.sum      = st_ff.sum + st_ff.tx_data;
               if (st_ff.pkt_left == 10'h000) begin
                  nxt_st.state = ST_TSUM;
               end else begin
                  nxt_st.pkt_left = st_ff.pkt_left - 10'h001;
                  nxt_st.state    = ST_FETCH;
               end
            end
         end
         // Check byte makes the packet sum to zero
         ST_TSUM: begin
            if (!st_ff.tx_valid) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data  = 8'h00 - st_ff.sum;
            end else if (tx_ready) begin
               nxt_st.tx_valid = 1'b0;
               nxt_st.state    = ST_TEND;
            end
         end
         ST_TEND: begin
            if (!st_ff.tx_valid) begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_data  = TERMINATOR;
            end else if (tx_ready) begin
               nxt_st.tx_valid = 1'b0;
               if (st_ff.is_err || st_ff.done) begin
                  nxt_st.state = ST_WAIT_CMD;
               end else begin
                  nxt_st.state = ST_WAIT_ACK;
               end
            end
         end
         default: begin
            nxt_st = '0;
         end
      endcase

      // Launch an error reply; the command is dropped afterwards
      if (start_err) begin
         nxt_st.is_err   = 1'b1;
         nxt_st.sts      = err_code;
         nxt_st.idx      = 4'h0;
         nxt_st.sum      = 8'h00;
         nxt_st.tx_valid = 1'b0;
         nxt_st.state    = ST_HEAD;
      end

      // Launch the next read-data reply
      if (start_data) begin
         nxt_st.is_err   = 1'b0;
         nxt_st.pkt_left = chunk_last;
         nxt_st.plen     = {1'b0, chunk_last} + 11'h002;
         nxt_st.idx      = 4'h0;
         nxt_st.sum      = 8'h00;
         nxt_st.tx_valid = 1'b0;
         nxt_st.state    = ST_HEAD;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign tx_valid       = st_ff.tx_valid;
   assign tx_data        = st_ff.tx_data;
   assign mem_req        = st_ff.mem_req;
   assign mem_addr       = st_ff.cur;
   assign start_location = st_ff.cur;
   assign end_location   = st_ff.endl;
   assign read_crc       = st_ff.crc;

endmodule // boot_read_handler

// File: rtl/boot_read_pkg.sv
package boot_read_pkg;

   // ----------------------------------------------------------------
   // Framing bytes and codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_START      = 8'h01;
   localparam logic [7:0]  DATA_START     = 8'h81;
   localparam logic [7:0]  TERMINATOR     = 8'h03;
   localparam logic [7:0]  READ_CODE      = 8'h15;
   localparam logic [7:0]  ERR_CODE       = 8'h95;
   localparam logic [7:0]  ERR_LEN        = 8'h0A;
   localparam logic [7:0]  UNUSED_BYTE    = 8'hFF;
   localparam logic [15:0] CMD_LEN        = 16'h0009;
   localparam logic [15:0] ACK_LEN        = 16'h0001;
   localparam logic [15:0] MAX_LEN        = 16'h0401;
   localparam logic [31:0] MAX_CHUNK_LAST = 32'h0000_03FF;

   // ----------------------------------------------------------------
   // Status codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  STS_PACKET     = 8'hC1;
   localparam logic [7:0]  STS_CHECKSUM   = 8'hC2;
   localparam logic [7:0]  STS_ACCEPT     = 8'hC3;
   localparam logic [7:0]  STS_PARAM      = 8'hC4;
   localparam logic [7:0]  STS_ADDRESS    = 8'hC5;
   localparam logic [7:0]  STS_SECURE     = 8'hC6;

   // ----------------------------------------------------------------
   // Reply layout and CRC
   // ----------------------------------------------------------------
   localparam logic [3:0]  ERR_HEAD_LAST  = 4'hC;
   localparam logic [3:0]  DATA_HEAD_LAST = 4'h3;
   localparam logic [31:0] CRC_POLY       = 32'h04C1_1DB7;
   localparam logic [31:0] CRC_INIT       = 32'hFFFF_FFFF;

   typedef enum logic [3:0] {
      ST_WAIT_CMD = 4'h0,
      ST_LNH      = 4'h1,
      ST_LNL      = 4'h2,
      ST_BODY     = 4'h3,
      ST_SUM      = 4'h4,
      ST_ETX      = 4'h5,
      ST_CHECK    = 4'h6,
      ST_HEAD     = 4'h7,
      ST_FETCH    = 4'h8,
      ST_DATA     = 4'h9,
      ST_TSUM     = 4'hA,
      ST_TEND     = 4'hB,
      ST_WAIT_ACK = 4'hC
   } fsm_t;

   // Area information for one location
   typedef struct packed {
      logic        in_range;
      logic [3:0]  area_kind;
      logic [31:0] read_unit_size;
   } area_info_t;

   // Whole state of the handler
   typedef struct packed {
      fsm_t        state;
      logic [15:0] len;
      logic [15:0] cnt;
      logic [7:0]  first_byte;
      logic [63:0] body;
      logic [7:0]  sum;
      logic [7:0]  sts;
      logic        is_err;
      logic        ack_mode;
      logic        done;
      logic [3:0]  idx;
      logic [31:0] cur;
      logic [31:0] endl;
      logic [9:0]  pkt_left;
      logic [10:0] plen;
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic        mem_req;
      logic [31:0] crc;
   } ctl_t;

endpackage

// File: rtl/crc32_byte.sv
`timescale 1ns/1ps

module crc32_byte
   import boot_read_pkg::*;
#(
   parameter logic [31:0] POLY = CRC_POLY
) (
   // Running value and data byte
   input  wire logic [31:0] crc_in,
   input  wire logic [7:0]  data_in,
   // Updated value
   output logic      [31:0] crc_out
);

   // ----------------------------------------------------------------
   // Eight left-shift steps, data MSB first
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] c;
      c = crc_in;
      for (int i = 7; i >= 0; i--) begin
         if (c[31] ^ data_in[i]) begin
            c = {c[30:0], 1'b0} ^ POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      crc_out = c;
   end

endmodule // crc32_byte

// File: tb/boot_read_handler_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the read handler
// ----------------------------------------------------------------
module boot_read_handler_monitor
   import boot_read_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Reply link
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_ready,
   // Memory port
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  mem_rdata
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_tx_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped or changed before taken");

   property p_tx_gap;
      tx_valid && tx_ready |=> !tx_valid;
   endproperty
   a_tx_gap: assert property (p_tx_gap) else $error("no idle cycle after a taken byte");

   property p_mem_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("read request not held");

   property p_mem_drop;
      mem_ack |=> !mem_req;
   endproperty
   a_mem_drop: assert property (p_mem_drop) else $error("read request kept after answer");

   property p_mem_data;
      mem_ack |=> tx_valid && tx_data == $past(mem_rdata);
   endproperty
   a_mem_data: assert property (p_mem_data) else $error("read byte not forwarded");

   property p_addr_step;
      mem_ack |=> mem_addr == $past(mem_addr) + 32'h1;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("read location did not advance");

   property p_no_overlap;
      mem_req |-> !tx_valid;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("send and fetch at once");

   property p_reset_idle;
      $rose(reset_n) |-> !tx_valid && !mem_req;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
endmodule // boot_read_handler_monitor

// File: tb/host_link_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host tool and memory seen by the handler
// ----------------------------------------------------------------
module host_link_model
   import boot_read_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Reply link
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   output logic             tx_ready,
   // Memory port
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             mem_ack = 1'b0,
   output logic      [7:0]  mem_rdata = 8'h00
);
   logic [7:0] got[$];
   logic [1:0] tick_ff = 2'h0;
   logic [1:0] wait_ff = 2'h0;

   // Link stalls one cycle in four
   assign tx_ready = (tick_ff != 2'h0);

   // Collect sent bytes; mapped memory answers after three waits
   always @(posedge core_clk) begin
      tick_ff <= tick_ff + 2'h1;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (tx_valid && tx_ready) got.push_back(tx_data);
      if (!reset_n) wait_ff <= 2'h0;
      else if (mem_req && !mem_ack) begin
         wait_ff <= wait_ff + 2'h1;
         if (wait_ff == 2'h2) begin
            wait_ff <= 2'h0;
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr[7:0] + 8'h3C;
         end
      end
   end
endmodule // host_link_model

// File: tb/boot_read_command_handler_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the read handler
// ----------------------------------------------------------------
module boot_read_command_handler_bench;
   import boot_read_pkg::*;
   logic        core_clk, reset_n, rx_valid, tx_valid, tx_ready, mem_req, mem_ack;
   logic [7:0]  rx_data, tx_data, mem_rdata;
   logic [31:0] mem_addr, start_location, end_location, read_crc;
   area_info_t  start_info, end_info;
   logic        range_accessible, range_secure, lifecycle_allows_read;
   logic        encrypted_write_pending, auth_level_zero, auth_level_one;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          n_rd = 0;
   logic [7:0]  exp_q[$];

   boot_read_handler dut (.*);
   host_link_model   m (.*);

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Count memory answers
   always @(posedge core_clk) if (mem_ack) n_rd++;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic dflt;
      start_info = '{1'b1, 4'h1, 32'h4};
      end_info = '{1'b1, 4'h1, 32'h4};
      range_accessible = 1'b1;
      range_secure = 1'b0;
      lifecycle_allows_read = 1'b1;
      encrypted_write_pending = 1'b0;
      auth_level_zero = 1'b0;
      auth_level_one = 1'b0;
      n_rd = 0;
   endtask

   // Bytes one per cycle, changed just after the edge
   task automatic send(logic [7:0] b[$]);
      foreach (b[i]) begin
         rx_valid = 1'b1;
         rx_data = b[i];
         @(posedge core_clk);
         #1;
      end
      rx_valid = 1'b0;
   endtask

   // Packet with length field, body, check byte and terminator
   task automatic send_pkt(logic [7:0] st, logic [7:0] b[$], logic [7:0] sadj, logic [7:0] term);
      logic [7:0] sum;
      sum = 8'h00;
      foreach (b[i]) sum += b[i];
      b.push_front(st);
      b.push_front(8'h55); // Noise ahead of the start byte
      b.push_back(8'h00 - sum + sadj);
      b.push_back(term);
      send(b);
   endtask

   task automatic send_cmd(logic [31:0] s, logic [31:0] e, logic [7:0] len, logic [7:0] sadj,
                           logic [7:0] term);
      logic [7:0] b[$];
      b = {8'h00, len, READ_CODE};
      for (int i = 3; i >= 0; i--) b.push_back(s[8*i+:8]);
      for (int i = 3; i >= 0; i--) b.push_back(e[8*i+:8]);
      if (len != 8'h09) b.push_back(8'h00);
      send_pkt(CMD_START, b, sadj, term);
   endtask

   // Expected reply: start, length, code, payload, check byte, terminator
   task automatic exp_pkt(logic [7:0] code, logic [7:0] p[$]);
      logic [15:0] n;
      logic [7:0]  sum;
      n = 16'(p.size() + 1);
      exp_q = {DATA_START, n[15:8], n[7:0], code};
      sum = n[15:8] + n[7:0] + code;
      foreach (p[i]) begin
         exp_q.push_back(p[i]);
         sum += p[i];
      end
      exp_q.push_back(8'h00 - sum);
      exp_q.push_back(TERMINATOR);
   endtask

   task automatic exp_err(logic [7:0] sts);
      logic [7:0] p[$];
      p = {sts};
      repeat (8) p.push_back(UNUSED_BYTE);
      exp_pkt(ERR_CODE, p);
   endtask

   task automatic exp_data(logic [31:0] a, int n);
      logic [7:0] p[$];
      for (int i = 0; i < n; i++) p.push_back(8'(a + i) + 8'h3C);
      exp_pkt(READ_CODE, p);
   endtask

   // Compare collected reply; nothing may follow it
   task automatic wait_reply(string nm);
      int k;
      k = 0;
      while (m.got.size() < exp_q.size() && k < 30000) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      foreach (exp_q[i]) chk(nm, exp_q[i], (i < m.got.size()) ? m.got[i] : 8'hxx);
      repeat (3) @(posedge core_clk);
      #1;
      chk({nm, " extra"}, 32'h0, m.got.size() - exp_q.size());
      m.got.delete();
   endtask

   task automatic t_read_small;
      logic [31:0] c;
      dflt();
      send_cmd(32'h100, 32'h107, 8'h09, 8'h00, TERMINATOR);
      exp_data(32'h100, 8);
      wait_reply("small read");
      c = CRC_INIT;
      for (int a = 0; a < 8; a++)
         for (int j = 7; j >= 0; j--)
            c = (c[31] ^ ((8'(a) + 8'h3C) >> j & 8'h1)) ? (c << 1) ^ CRC_POLY : c << 1;
      chk("read crc", c, read_crc);
      chk("reads", 8, n_rd);
      chk("end location", 32'h107, end_location);
      chk("start location", 32'h108, start_location);
      chk("next address", 32'h108, mem_addr);
   endtask

   task automatic t_errors;
      logic [31:0] s;
      logic [7:0]  sts, len, sadj, term;
      for (int c = 0; c < 14; c++) begin
         dflt();
         s = 32'h100;
         len = 8'h09;
         sadj = 8'h00;
         term = TERMINATOR;
         sts = STS_PARAM;
         case (c)
            0: begin
               term = 8'h00;
               sts = STS_PACKET;
            end
            1: begin
               sadj = 8'h01;
               sts = STS_CHECKSUM;
            end
            2: begin
               len = 8'h0A;
               sts = STS_PACKET;
            end
            3: begin
               lifecycle_allows_read = 1'b0;
               sts = STS_ACCEPT;
            end
            4: begin
               encrypted_write_pending = 1'b1;
               sts = STS_ACCEPT;
            end
            5: s = 32'h108;
            6: end_info.in_range = 1'b0;
            7: end_info.area_kind = 4'h2;
            8: begin
               start_info.read_unit_size = 32'h0;
               end_info.read_unit_size = 32'h0;
            end
            9: s = 32'h102;
            10: begin
               range_accessible = 1'b0;
               sts = STS_ADDRESS;
            end
            11: begin
               auth_level_one = 1'b1;
               range_secure = 1'b1;
               sts = STS_SECURE;
            end
            12: begin
               auth_level_zero = 1'b1;
               sts = STS_SECURE;
            end
            default: begin
               lifecycle_allows_read = 1'b0;
               s = 32'h108;
               auth_level_zero = 1'b1;
               sts = STS_ACCEPT;
            end
         endcase
         send_cmd(s, 32'h107, len, sadj, term);
         exp_err(sts);
         wait_reply($sformatf("error case %0d", c));
         chk("reads on error", 0, n_rd);
      end
   endtask

   // 1025 bytes: full reply, host answer, then rest or error
   task automatic t_multi(logic [7:0] code, logic [7:0] sadj, logic [7:0] sts);
      dflt();
      start_info.read_unit_size = 32'h1;
      end_info.read_unit_size = 32'h1;
      send_cmd(32'h1000, 32'h1400, 8'h09, 8'h00, TERMINATOR);
      exp_data(32'h1000, 1024);
      wait_reply("first block");
      send_pkt(DATA_START, {8'h00, 8'h01, code}, sadj, TERMINATOR);
      if (sts == 8'h00) exp_data(32'h1400, 1);
      else exp_err(sts);
      wait_reply("after host answer");
      chk("reads", (sts == 8'h00) ? 1025 : 1024, n_rd);
   endtask

   // Main sequence
   initial begin
      reset_n = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      dflt();
      repeat (2) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      t_read_small();
      t_errors();
      t_multi(READ_CODE, 8'h00, 8'h00);
      t_multi(8'h16, 8'h00, STS_PACKET);
      t_multi(READ_CODE, 8'h01, STS_CHECKSUM);
      stop_test();
   end

   // Watchdog
   initial begin
      #(90000 * 8);
      n_mismatch++;
      stop_test();
   end
endmodule // boot_read_command_handler_bench

bind boot_read_handler boot_read_handler_monitor mon (.*);
